// ### design/spmsp_regs.vh
`ifndef SPMSP_REGS_VH
`define SPMSP_REGS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define SPMSP_ADDR_CTRL 4'h0
`define SPMSP_ADDR_STAT 4'h4
`define SPMSP_ADDR_DATA 4'h8
`define SPMSP_ADDR_PINS 4'hC

// ****************************************************************
// Control field positions
// ****************************************************************
`define SPMSP_CTRL_IRQ_EN 7
`define SPMSP_CTRL_ENABLE 6
`define SPMSP_CTRL_ORDER 5
`define SPMSP_CTRL_MASTER 4
`define SPMSP_CTRL_IDLE_LVL 3
`define SPMSP_CTRL_PHASE 2
`define SPMSP_CTRL_RATE_HI 1
`define SPMSP_CTRL_RATE_LO 0

// ****************************************************************
// Status field positions
// ****************************************************************
`define SPMSP_STAT_DONE 7
`define SPMSP_STAT_COLL 6
`define SPMSP_STAT_DOUBLE 0

// ****************************************************************
// Pin config fields: direction bits and general output levels
// ****************************************************************
`define SPMSP_PIN_MOSI 0
`define SPMSP_PIN_MISO 1
`define SPMSP_PIN_SCK 2
`define SPMSP_PIN_SS 3
`define SPMSP_PIN_OUT_LSB 4

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define SPMSP_RST_BYTE 8'h00
`define SPMSP_RST_WORD 32'h00000000
`define SPMSP_RST_NIB 4'h0
`define SPMSP_RST_DIV 7'h00
`define SPMSP_LAST_EDGE 4'hF
`define SPMSP_DIV_ONE 7'h01

`endif

// ### design/spmsp_port.v
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`include "spmsp_regs.vh"

// Functional notes
// - Master: data write starts clock generator, shifts eight bits out
// - Master: after one byte clock stops, done flag set, irq if enabled
// - Master: port never drives slave select by itself
// - Full duplex: MOSI out, MISO in; master raises SS between packets
// - Slave: SS high keeps port idle, MISO released, SCK ignored
// - Slave: data writes while SS high accepted for next transfer
// - Slave: done flag set after full byte; irq if enabled
// - Transmit single buffered; receive buffer overwritten by next byte
// - Last received byte stays readable after transfer ends
// - Enabled port overrides pin directions per master or slave role
// - Slave: SS always input; SS low lets MISO drive if configured
// - Slave: SS high resets bit count and drops partial byte
// - Master with SS output: SS is plain general output
// - Master with SS input pulled low: become slave, set done flag
// - Irq enable bit with done flag and global enable requests irq
// - Enable bit must be one for any transfer
// - Order bit one sends LSB first, zero sends MSB first
// - Done flag cleared by vector ack or status read then data access
// - Data write during transfer sets collision flag, cleared by status read then data access, not by vector ack
// - Rate bits and double bit divide clock by 2 to 128 in master
// - Idle level sets SCK idle; phase picks leading or trailing sample
module spmsp_port (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // Avalon-MM slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Interrupt request
    input wire global_irq_en,
    input wire irq_ack,
    output reg irq_req,
    // Serial clock pin
    input wire sck_i,
    output reg sck_o,
    output reg sck_oe,
    // Master out slave in pin
    input wire mosi_i,
    output reg mosi_o,
    output reg mosi_oe,
    // Master in slave out pin
    input wire miso_i,
    output reg miso_o,
    output reg miso_oe,
    // Slave select pin, active low
    input wire ss_n_i,
    output reg ss_n_o,
    output reg ss_n_oe
);

    // ****************************************************************
    // Engine states
    // ****************************************************************
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_MAST = 3'h2;
    localparam [2:0] ST_SLAV = 3'h4;

    // ****************************************************************
    // Functions
    // ****************************************************************
    function [7:0] shift_in;
        input [7:0] sh;
        input bit_in;
        input lsb_first;
        begin
            if (lsb_first) begin
                shift_in = {bit_in, sh[7:1]};
            end else begin
                shift_in = {sh[6:0], bit_in};
            end
        end
    endfunction

    function out_bit;
        input [7:0] sh;
        input lsb_first;
        begin
            out_bit = lsb_first ? sh[0] : sh[7];
        end
    endfunction

    // Half SCK period in system clocks
    function [6:0] half_period;
        input dbl;
        input [1:0] rate;
        begin
            case ({dbl, rate})
                3'h0: half_period = 7'h02;
                3'h1: half_period = 7'h08;
                3'h2: half_period = 7'h20;
                3'h3: half_period = 7'h40;
                3'h4: half_period = 7'h01;
                3'h5: half_period = 7'h04;
                3'h6: half_period = 7'h10;
                default: half_period = 7'h20;
            endcase
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    reg [7:0] serial_port_control_q;
    reg transfer_done_flag_q;
    reg write_collision_flag_q;
    reg double_rate_bit_q;
    reg clear_armed_q;
    reg [7:0] pin_cfg_q;
    reg [7:0] tx_q;
    reg [7:0] sh_q;
    reg [7:0] serial_data_buffer_q;
    reg smp_q;
    reg samp_pend_q;
    reg out_q;
    reg sck_q;
    reg sck_prev_q;
    reg [3:0] edge_cnt_q;
    reg [6:0] div_cnt_q;
    reg [2:0] st_q;
    reg [2:0] st_d;

    wire irq_en = serial_port_control_q[`SPMSP_CTRL_IRQ_EN];
    wire port_enable_bit = serial_port_control_q[`SPMSP_CTRL_ENABLE];
    wire bit_order_select = serial_port_control_q[`SPMSP_CTRL_ORDER];
    wire master_select_bit = serial_port_control_q[`SPMSP_CTRL_MASTER];
    wire clock_idle_level = serial_port_control_q[`SPMSP_CTRL_IDLE_LVL];
    wire clock_sample_edge = serial_port_control_q[`SPMSP_CTRL_PHASE];
    wire [1:0] rate_sel = serial_port_control_q[`SPMSP_CTRL_RATE_HI:`SPMSP_CTRL_RATE_LO];
    wire ss_is_out = pin_cfg_q[`SPMSP_PIN_SS];

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire bus_req = avs_read | avs_write;
    wire bus_acc = bus_req & ~avs_waitrequest;
    wire lane0 = avs_byteenable[0];
    wire hit_ctrl = avs_address == `SPMSP_ADDR_CTRL;
    wire hit_stat = avs_address == `SPMSP_ADDR_STAT;
    wire hit_data = avs_address == `SPMSP_ADDR_DATA;
    wire hit_pins = avs_address == `SPMSP_ADDR_PINS;
    wire wr_lane = bus_acc & avs_write & lane0;
    wire data_acc = bus_acc & hit_data;
    wire data_wr = wr_lane & hit_data;
    wire stat_rd = bus_acc & avs_read & hit_stat;

    // ****************************************************************
    // Engine combinational
    // ****************************************************************
    wire [6:0] half_cnt = half_period(double_rate_bit_q, rate_sel);
    wire busy = st_q[1] | (st_q[2] & (edge_cnt_q != `SPMSP_RST_NIB));
    wire demote = port_enable_bit & master_select_bit & ~ss_is_out & ~ss_n_i;
    wire m_ev = st_q[1] & (div_cnt_q == half_cnt - `SPMSP_DIV_ONE);
    wire s_ev = st_q[2] & (sck_i != sck_prev_q);
    wire ev = m_ev | s_ev;
    wire lvl = st_q[1] ? ~sck_q : sck_i;
    wire lead = lvl != clock_idle_level;
    wire sample_ev = ev & (lead != clock_sample_edge);
    wire setup_ev = ev & (lead == clock_sample_edge);
    wire din = st_q[1] ? miso_i : mosi_i;
    // Master with phase bit zero takes MISO one cycle late, when the pin edge has happened
    wire smp_bit = samp_pend_q ? din : smp_q;
    wire done = ev & (edge_cnt_q == `SPMSP_LAST_EDGE);
    wire start_m = data_wr & ~busy & port_enable_bit & master_select_bit & ~demote;
    wire sel_s = port_enable_bit & ~master_select_bit & ~ss_n_i;
    reg [7:0] sh_n;
    reg out_n;

    always @* begin
        sh_n = sh_q;
        out_n = out_q;
        if (clock_sample_edge) begin
            if (setup_ev) begin
                out_n = out_bit(sh_q, bit_order_select);
            end
            if (sample_ev) begin
                sh_n = shift_in(sh_q, din, bit_order_select);
            end
        end else begin
            if (setup_ev) begin
                sh_n = shift_in(sh_q, smp_bit, bit_order_select);
                out_n = out_bit(sh_n, bit_order_select);
            end
        end
    end

    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (start_m) begin
                    st_d = ST_MAST;
                end else if (sel_s) begin
                    st_d = ST_SLAV;
                end
            end
            ST_MAST: begin
                if (demote | ~port_enable_bit | done) begin
                    st_d = ST_IDLE;
                end
            end
            ST_SLAV: begin
                if (~sel_s) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // ****************************************************************
    // Shift engine
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
            sh_q <= `SPMSP_RST_BYTE;
            tx_q <= `SPMSP_RST_BYTE;
            serial_data_buffer_q <= `SPMSP_RST_BYTE;
            smp_q <= 1'b0;
            samp_pend_q <= 1'b0;
            out_q <= 1'b0;
            sck_q <= 1'b0;
            sck_prev_q <= 1'b0;
            edge_cnt_q <= `SPMSP_RST_NIB;
            div_cnt_q <= `SPMSP_RST_DIV;
        end else begin
            st_q <= st_d;
            sck_prev_q <= sck_i;
            if (data_wr & ~busy) begin
                tx_q <= avs_writedata[7:0];
            end
            samp_pend_q <= sample_ev & st_q[1];
            if ((sample_ev & ~st_q[1]) | samp_pend_q) begin
                smp_q <= din;
            end
            if (start_m) begin
                sh_q <= avs_writedata[7:0];
                out_q <= out_bit(avs_writedata[7:0], bit_order_select);
                edge_cnt_q <= `SPMSP_RST_NIB;
                div_cnt_q <= `SPMSP_RST_DIV;
                sck_q <= clock_idle_level;
            end else if (st_d[0] & ~done) begin
                sh_q <= tx_q;
                out_q <= out_bit(tx_q, bit_order_select);
                edge_cnt_q <= `SPMSP_RST_NIB;
                div_cnt_q <= `SPMSP_RST_DIV;
                sck_q <= clock_idle_level;
            end else begin
                if (done) begin
                    serial_data_buffer_q <= sh_n;
                    edge_cnt_q <= `SPMSP_RST_NIB;
                    sh_q <= tx_q;
                    out_q <= clock_sample_edge ? out_n : out_bit(tx_q, bit_order_select);
                end else begin
                    sh_q <= sh_n;
                    out_q <= out_n;
                    if (ev) begin
                        edge_cnt_q <= edge_cnt_q + 4'h1;
                    end
                    if (st_q[2] & ~busy & ~ev) begin
                        sh_q <= tx_q;
                        out_q <= out_bit(tx_q, bit_order_select);
                    end
                end
                if (st_q[1]) begin
                    if (m_ev) begin
                        div_cnt_q <= `SPMSP_RST_DIV;
                        sck_q <= ~sck_q;
                    end else begin
                        div_cnt_q <= div_cnt_q + `SPMSP_DIV_ONE;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Registers and flags
    // ****************************************************************
    wire flag_clr = clear_armed_q & data_acc;
    wire done_set = done | demote;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            serial_port_control_q <= `SPMSP_RST_BYTE;
            transfer_done_flag_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            double_rate_bit_q <= 1'b0;
            clear_armed_q <= 1'b0;
            pin_cfg_q <= `SPMSP_RST_BYTE;
        end else begin
            if (wr_lane & hit_ctrl) begin
                serial_port_control_q <= avs_writedata[7:0];
            end
            if (demote) begin
                serial_port_control_q[`SPMSP_CTRL_MASTER] <= 1'b0;
            end
            if (wr_lane & hit_stat) begin
                double_rate_bit_q <= avs_writedata[`SPMSP_STAT_DOUBLE];
            end
            if (wr_lane & hit_pins) begin
                pin_cfg_q <= avs_writedata[7:0];
            end
            // Set wins over clear
            transfer_done_flag_q <= done_set |
                (transfer_done_flag_q & ~flag_clr & ~irq_ack);
            write_collision_flag_q <= (data_wr & busy) |
                (write_collision_flag_q & ~flag_clr);
            if (stat_rd & (transfer_done_flag_q | write_collision_flag_q)) begin
                clear_armed_q <= 1'b1;
            end else if (data_acc) begin
                clear_armed_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Bus answer: one wait state per access
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= `SPMSP_RST_WORD;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (bus_req & avs_waitrequest) begin
                avs_readdata <= `SPMSP_RST_WORD;
                if (avs_read & hit_ctrl) begin
                    avs_readdata[7:0] <= serial_port_control_q;
                end
                if (avs_read & hit_stat) begin
                    avs_readdata[`SPMSP_STAT_DONE] <= transfer_done_flag_q;
                    avs_readdata[`SPMSP_STAT_COLL] <= write_collision_flag_q;
                    avs_readdata[`SPMSP_STAT_DOUBLE] <= double_rate_bit_q;
                end
                if (avs_read & hit_data) begin
                    avs_readdata[7:0] <= serial_data_buffer_q;
                end
                if (avs_read & hit_pins) begin
                    avs_readdata[7:0] <= pin_cfg_q;
                    avs_readdata[11:8] <= {ss_n_i, sck_i, miso_i, mosi_i};
                end
            end
        end
    end

    // ****************************************************************
    // Pin overrides and interrupt
    // ****************************************************************
    wire en_m = port_enable_bit & master_select_bit;
    wire en_s = port_enable_bit & ~master_select_bit;
    wire [3:0] gp_out = pin_cfg_q[7:`SPMSP_PIN_OUT_LSB];

    always @(posedge clk_sys) begin
        if (!nrst) begin
            irq_req <= 1'b0;
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
            mosi_o <= 1'b0;
            mosi_oe <= 1'b0;
            miso_o <= 1'b0;
            miso_oe <= 1'b0;
            ss_n_o <= 1'b0;
            ss_n_oe <= 1'b0;
        end else begin
            irq_req <= irq_en & transfer_done_flag_q & global_irq_en;
            sck_o <= en_m ? sck_q : gp_out[`SPMSP_PIN_SCK];
            mosi_o <= en_m ? out_q : gp_out[`SPMSP_PIN_MOSI];
            miso_o <= en_s ? out_q : gp_out[`SPMSP_PIN_MISO];
            ss_n_o <= gp_out[`SPMSP_PIN_SS];
            sck_oe <= ~en_s & pin_cfg_q[`SPMSP_PIN_SCK];
            mosi_oe <= ~en_s & pin_cfg_q[`SPMSP_PIN_MOSI];
            miso_oe <= ~en_m & pin_cfg_q[`SPMSP_PIN_MISO] &
                ~(en_s & ss_n_i);
            ss_n_oe <= ~en_s & pin_cfg_q[`SPMSP_PIN_SS];
        end
    end

endmodule

// ### verification/spmsp_assertions.sv
`timescale 1ns/1ns
`include "spmsp_regs.vh"
// ****
// Port checker
// ****
module spmsp_chk (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // Bus
    input wire [3:0] avs_address,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire avs_waitrequest,
    // Irq
    input wire global_irq_en,
    input wire irq_req,
    // Pins
    input wire sck_o,
    input wire sck_oe,
    input wire mosi_oe,
    input wire miso_oe,
    input wire ss_n_i,
    input wire ss_n_o,
    input wire ss_n_oe
);
    logic en_q, ie_q, ms_q, dbl_q, ss_dir_q;
    logic [1:0] rate_q, stl_q;
    wire wr_d = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire ctl_w = wr_d && avs_address == `SPMSP_ADDR_CTRL;
    // Shadow of software settings
    always @(posedge clk_sys) begin
        if (!nrst) begin
            {ie_q, en_q, ms_q, rate_q, dbl_q, ss_dir_q, stl_q} <= 9'h000;
        end else begin
            if (ctl_w) begin
                {ie_q, en_q} <= avs_writedata[7:6];
                ms_q <= avs_writedata[4];
                rate_q <= avs_writedata[1:0];
            end
            if (wr_d && avs_address == `SPMSP_ADDR_STAT) dbl_q <= avs_writedata[0];
            if (wr_d && avs_address == `SPMSP_ADDR_PINS) ss_dir_q <= avs_writedata[3];
            if (ctl_w) stl_q <= 2'h0;
            else if (stl_q != 2'h3) stl_q <= stl_q + 2'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_rst_out;
        $rose(nrst) |-> avs_waitrequest && !irq_req && !sck_oe && !mosi_oe && !miso_oe && !ss_n_oe;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
    property p_irq;
        irq_req |-> $past(ie_q) && $past(global_irq_en);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without enables");
    property p_rate;
        sck_oe && $changed(sck_o) && !(dbl_q && rate_q == 2'h0) |=> $stable(sck_o);
    endproperty
    a_rate: assert property (p_rate) else $error("serial clock too fast");
    property p_ss_plain;
        $changed(ss_n_o) || $changed(ss_n_oe) |-> $past(wr_d) || $past(wr_d, 2) || $past(wr_d, 3);
    endproperty
    a_ss_plain: assert property (p_ss_plain) else $error("select moved by itself");
    property p_slv_idle;
        stl_q == 2'h3 && en_q && !ms_q && miso_oe |-> !$past(ss_n_i) || !$past(ss_n_i, 2);
    endproperty
    a_slv_idle: assert property (p_slv_idle) else $error("miso driven unselected");
    property p_slv_dir;
        stl_q == 2'h3 && en_q && !ms_q |-> !sck_oe && !mosi_oe && !ss_n_oe;
    endproperty
    a_slv_dir: assert property (p_slv_dir) else $error("slave drives input pin");
    property p_mst_dir;
        stl_q == 2'h3 && en_q && ms_q && $past(ss_n_i) && $past(ss_n_i, 2) |-> !miso_oe;
    endproperty
    a_mst_dir: assert property (p_mst_dir) else $error("master drives miso");
    sequence s_sel_low;
        stl_q == 2'h3 && en_q && ms_q && !ss_dir_q && !ss_n_i;
    endsequence
    sequence s_demoted;
        !sck_oe && !mosi_oe;
    endsequence
    property p_demote;
        s_sel_low |-> ##[1:4] s_demoted;
    endproperty
    a_demote: assert property (p_demote) else $error("no demotion on select");
endmodule

bind spmsp_port spmsp_chk u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .global_irq_en(global_irq_en), .irq_req(irq_req),
    .sck_o(sck_o), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_i(ss_n_i),
    .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe)
);

// ### verification/spmsp_peer.sv
`timescale 1ns/1ns
// ****
// Far side serial slave
// ****
module spmsp_peer (
    // Serial lines
    input wire sck,
    input wire ss_n,
    input wire mosi,
    output logic miso,
    // Byte data
    input wire lsb,
    input wire [7:0] tx,
    output logic [7:0] rx
);
    logic [2:0] n;
    initial miso = 1'h1;
    initial rx = 8'h00;
    always @(negedge ss_n) begin
        n = 3'h0;
        miso = lsb ? tx[0] : tx[7];
    end
    always @(posedge sck) if (!ss_n) rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
    always @(negedge sck) if (!ss_n) begin
        n = n + 3'h1;
        miso = lsb ? tx[n] : tx[3'h7 - n];
    end
    // Released line shows no stale bit
    always @(posedge ss_n) miso = ~miso;
endmodule

// ### verification/tb.sv
`timescale 1ns/1ns
`include "spmsp_regs.vh"
module tb;
    // ****
    // Signals
    // ****
    logic clk_sys = 1'h0;
    logic nrst = 1'h0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic global_irq_en = 1'h0;
    logic irq_ack = 1'h0;
    logic tb_sck = 1'h0;
    logic tb_mosi = 1'h0;
    logic tb_ss_n = 1'h1;
    logic p_lsb = 1'h0;
    logic [7:0] p_tx = 8'h00;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, irq_req, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    wire ss_n_o, ss_n_oe, p_miso;
    wire [7:0] p_rx;
    wire sck_w = sck_oe ? sck_o : tb_sck;
    wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
    wire miso_w = miso_oe ? miso_o : p_miso;
    wire ss_w = ss_n_oe ? ss_n_o : tb_ss_n;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int seed = 89;
    int exp_q[$];
    logic [31:0] q;
    logic [7:0] d, pd, g;
    always #50 clk_sys = ~clk_sys;
    spmsp_port dut (
        .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .global_irq_en(global_irq_en), .irq_ack(irq_ack), .irq_req(irq_req),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
        .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe)
    );
    spmsp_peer u_peer (.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .miso(p_miso),
        .lsb(p_lsb), .tx(p_tx), .rx(p_rx));
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic bus(input logic is_rd, input logic [3:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h000000, wd};
        avs_read <= is_rd;
        avs_write <= !is_rd;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 100);
        q = avs_readdata;
        if (n == 100) err_total++;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        bus(1'h0, a, v);
    endtask
    task automatic rd(input logic [3:0] a);
        bus(1'h1, a, 8'h00);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            rd(`SPMSP_ADDR_STAT);
            n++;
        end while (q[7] !== 1'h1 && n < 1000);
    endtask
    task automatic sbyte(input logic [7:0] m, input int n);
        tb_ss_n <= 1'h0;
        repeat (4) @(posedge clk_sys);
        if (n == 8) chk(miso_oe, 1'h1);
        for (int b = 7; b > 7 - n; b--) begin
            tb_mosi <= m[b];
            repeat (4) @(posedge clk_sys);
            g[b] = miso_w;
            tb_sck <= 1'h1;
            repeat (4) @(posedge clk_sys);
            tb_sck <= 1'h0;
        end
        repeat (4) @(posedge clk_sys);
        tb_ss_n <= 1'h1;
        tb_mosi <= ~tb_mosi;
        repeat (4) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test;
        end
    end
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            rd(4'(i * 4 + (i / 4) * 2));
            chk(q & (i == 3 ? 32'hFF : 32'hFFFFFFFF), 32'h0);
        end
        wr(`SPMSP_ADDR_CTRL, 8'h10);
        wr(`SPMSP_ADDR_DATA, 8'h5A);
        repeat (100) @(posedge clk_sys);
        rd(`SPMSP_ADDR_STAT);
        chk(q, 32'h0);
        wr(`SPMSP_ADDR_STAT, 8'hFF);
        rd(`SPMSP_ADDR_STAT);
        chk(q, 32'h1);
        global_irq_en <= 1'h1;
        wr(`SPMSP_ADDR_PINS, 8'h8D);
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            pd = $random(seed);
            p_tx <= pd;
            p_lsb <= i[0];
            exp_q.push_back(d);
            exp_q.push_back(pd);
            wr(`SPMSP_ADDR_STAT, {7'h00, i[2]});
            wr(`SPMSP_ADDR_CTRL, {i[1], 1'h1, i[0], 1'h1, 2'h0, i[1:0]});
            wr(`SPMSP_ADDR_PINS, 8'h0D);
            wr(`SPMSP_ADDR_DATA, d);
            chk(ss_w, 1'h0);
            if (i == 3) wr(`SPMSP_ADDR_DATA, pd ^ 8'hFF);
            wait_done;
            chk(q, {24'h0, 1'h1, i == 3, 5'h00, i[2]});
            chk(p_rx, exp_q.pop_front());
            chk(irq_req, i[1]);
            if (i[1]) begin
                @(posedge clk_sys);
                irq_ack <= 1'h1;
                @(posedge clk_sys);
                irq_ack <= 1'h0;
                repeat (3) @(posedge clk_sys);
                chk(irq_req, 1'h0);
            end
            rd(`SPMSP_ADDR_DATA);
            chk(q, exp_q.pop_front());
            rd(`SPMSP_ADDR_STAT);
            chk(q, {31'h0, i[2]});
            wr(`SPMSP_ADDR_PINS, 8'h8D);
        end
        wr(`SPMSP_ADDR_STAT, 8'h00);
        wr(`SPMSP_ADDR_PINS, 8'h05);
        wr(`SPMSP_ADDR_CTRL, 8'hD0);
        tb_ss_n <= 1'h0;
        repeat (6) @(posedge clk_sys);
        chk({sck_oe, mosi_oe}, 2'h0);
        chk(irq_req, 1'h1);
        rd(`SPMSP_ADDR_CTRL);
        chk(q, 32'hC0);
        rd(`SPMSP_ADDR_STAT);
        chk(q, 32'h80);
        rd(`SPMSP_ADDR_DATA);
        tb_ss_n <= 1'h1;
        wr(`SPMSP_ADDR_CTRL, 8'h50);
        rd(`SPMSP_ADDR_CTRL);
        chk(q, 32'h50);
        wr(`SPMSP_ADDR_PINS, 8'h02);
        wr(`SPMSP_ADDR_CTRL, 8'h40);
        repeat (4) @(posedge clk_sys);
        chk(miso_oe, 1'h0);
        d = $random(seed);
        wr(`SPMSP_ADDR_DATA, d);
        sbyte(8'hA5, 3);
        pd = $random(seed);
        sbyte(pd, 8);
        chk(g, d);
        d = $random(seed);
        sbyte(d, 8);
        rd(`SPMSP_ADDR_STAT);
        chk(q, 32'h80);
        rd(`SPMSP_ADDR_DATA);
        chk(q, d);
        finish_test;
    end
endmodule
